// ===== verilog/acc_top.sv
`default_nettype none
module acc_top #(
  parameter int CAL_CYCLES = acc_pkg::CAL_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0][13:0] meas_offset,
  input wire logic [1:0][12:0] meas_gain,
  output logic [7:0] reg_rdata_q,
  output logic [1:0][13:0] offset_coef_q,
  output logic [1:0][12:0] gain_coef_q,
  output logic [1:0] cal_source_q,
  output logic [1:0] cal_busy_q
);
  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0] ptr_q;
  logic [2:0] cfg_q [2];
  logic [7:0] lin_q [2][acc_pkg::LIN_LOCS];
  logic [2:0] done_w [2];
  logic [1:0] busy_w;

  // ****************************************************************
  // Access decode.
  // ****************************************************************
  wire logic ptr_wr = reg_wr && (reg_sel == acc_pkg::SEL_PTR);
  wire logic coef_sel = (reg_sel == acc_pkg::SEL_COEF);
  wire logic coef_wr = reg_wr && coef_sel;
  wire logic coef_acc = (reg_wr || reg_rd) && coef_sel;
  wire logic [1:0] cfg_wr = {reg_wr && (reg_sel == acc_pkg::SEL_CFG1),
                             reg_wr && (reg_sel == acc_pkg::SEL_CFG0)};
  wire logic [5:0] loc = ptr_q[5:0];
  wire logic conv = ptr_q[acc_pkg::PTR_SEL_BIT];
  wire logic auto_inc = ptr_q[acc_pkg::PTR_INC_BIT];
  wire logic lin_hit = (loc <= acc_pkg::LOC_LIN_LAST);
  wire logic [4:0] lin_idx = loc[4:0];
  wire logic [13:0] off_sel = offset_coef_q[conv];
  wire logic [12:0] gain_sel = gain_coef_q[conv];

  // ****************************************************************
  // Coefficient port and register read data.
  // ****************************************************************
  wire logic [7:0] coef_rd =
    lin_hit ? lin_q[conv][lin_idx] :
    (loc == acc_pkg::LOC_OFF_LO) ? off_sel[7:0] :
    (loc == acc_pkg::LOC_OFF_HI) ? {2'b00, off_sel[13:8]} :
    (loc == acc_pkg::LOC_GAIN_LO) ? gain_sel[7:0] :
    (loc == acc_pkg::LOC_GAIN_HI) ? {3'b000, gain_sel[12:8]} : 8'h00;
  wire logic [7:0] rd_mux =
    (reg_sel == acc_pkg::SEL_PTR) ? ptr_q :
    coef_sel ? coef_rd :
    (reg_sel == acc_pkg::SEL_CFG0) ? {4'h0, cal_source_q[0], cfg_q[0]} :
    {4'h0, cal_source_q[1], cfg_q[1]};

  // ****************************************************************
  // Pointer and read register.
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      ptr_q <= acc_pkg::PTR_RESET;
      reg_rdata_q <= 8'h00;
    end else begin
      if (ptr_wr) begin
        ptr_q <= reg_wdata;
      end else if (coef_acc && auto_inc) begin
        ptr_q[5:0] <= loc + 6'h01;
      end
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Per-converter configuration, coefficients and engines.
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int c = 0; c < 2; c++) begin
        cfg_q[c] <= 3'h0;
        cal_source_q[c] <= 1'b0;
        cal_busy_q[c] <= 1'b0;
        offset_coef_q[c] <= acc_pkg::OFF_RESET;
        gain_coef_q[c] <= acc_pkg::GAIN_RESET;
        for (int i = 0; i < acc_pkg::LIN_LOCS; i++) begin
          lin_q[c][i] <= 8'h00;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        cal_busy_q[c] <= busy_w[c];
        // A software write in the finishing cycle wins over the clear.
        if (cfg_wr[c]) begin
          cfg_q[c] <= reg_wdata[2:0];
          cal_source_q[c] <= reg_wdata[acc_pkg::CFG_SRC_BIT];
        end else begin
          cfg_q[c] <= cfg_q[c] & ~done_w[c];
        end
        if (coef_wr && (conv == c[0])) begin
          if (lin_hit) begin
            lin_q[c][lin_idx] <= reg_wdata;
          end
          if (loc == acc_pkg::LOC_OFF_LO) begin
            offset_coef_q[c][7:0] <= reg_wdata;
          end
          if (loc == acc_pkg::LOC_OFF_HI) begin
            offset_coef_q[c][13:8] <= reg_wdata[5:0];
          end
          if (loc == acc_pkg::LOC_GAIN_LO) begin
            gain_coef_q[c][7:0] <= reg_wdata;
          end
          if (loc == acc_pkg::LOC_GAIN_HI) begin
            gain_coef_q[c][12:8] <= reg_wdata[4:0];
          end
        end
        // A finished calibration overrides a same-cycle software write.
        if (done_w[c][acc_pkg::CFG_OFF_BIT]) begin
          offset_coef_q[c] <= meas_offset[c];
        end
        if (done_w[c][acc_pkg::CFG_GAIN_BIT]) begin
          gain_coef_q[c] <= meas_gain[c];
        end
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_conv
    acc_cal_if cal_if ();
    assign cal_if.start = cfg_q[g];
    assign done_w[g] = cal_if.done;
    assign busy_w[g] = cal_if.busy;
    acc_cal_engine #(.CAL_CYCLES(CAL_CYCLES)) u_engine (
      .mclk(mclk),
      .reset(reset),
      .cal(cal_if.engine)
    );
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_lin_clear: assert property (@(posedge mclk) disable iff (reset)
    (done_w[0][0] && !cfg_wr[0]) |=> !cfg_q[0][0])
    else $error("linearity start bit not cleared at completion");
  a_off_clear: assert property (@(posedge mclk) disable iff (reset)
    (done_w[1][1] && !cfg_wr[1]) |=> !cfg_q[1][1] && offset_coef_q[1] == $past(meas_offset[1]))
    else $error("offset completion not applied");
  a_gain_clear: assert property (@(posedge mclk) disable iff (reset)
    (done_w[1][2] && !cfg_wr[1]) |=> !cfg_q[1][2] && gain_coef_q[1] == $past(meas_gain[1]))
    else $error("gain completion not applied");
  a_source_bit: assert property (@(posedge mclk) disable iff (reset)
    cfg_wr[1] |=> cal_source_q[1] == $past(reg_wdata[3]))
    else $error("source select not taken");
  a_auto_step: assert property (@(posedge mclk) disable iff (reset)
    (coef_acc && auto_inc && !ptr_wr) |=>
      ptr_q[5:0] == $past(ptr_q[5:0]) + 6'h01 && ptr_q[7:6] == $past(ptr_q[7:6]))
    else $error("auto-increment step wrong");
  a_no_step: assert property (@(posedge mclk) disable iff (reset)
    (coef_acc && !auto_inc && !ptr_wr) |=> ptr_q == $past(ptr_q))
    else $error("pointer moved without auto-increment");
  a_off_hi_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && coef_sel && loc == acc_pkg::LOC_OFF_HI) |=>
      reg_rdata_q == {2'b00, $past(off_sel[13:8])})
    else $error("offset high byte read wrong");
  a_gain_hi_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && coef_sel && loc == acc_pkg::LOC_GAIN_HI) |=> reg_rdata_q[7:5] == 3'b000)
    else $error("gain high unused bits not zero");
  a_lin_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && coef_sel && lin_hit) |=> reg_rdata_q == $past(lin_q[conv][lin_idx]))
    else $error("linearity coefficient read wrong");
endmodule
`default_nettype wire

// ===== verilog/acc_pkg.sv
`default_nettype none
package acc_pkg;
  // ****************************************************************
  // Register selects and field positions.
  // ****************************************************************
  localparam logic [1:0] SEL_PTR = 2'h0;
  localparam logic [1:0] SEL_COEF = 2'h1;
  localparam logic [1:0] SEL_CFG0 = 2'h2;
  localparam logic [1:0] SEL_CFG1 = 2'h3;
  localparam logic [7:0] PTR_RESET = 8'hD7;
  localparam int PTR_INC_BIT = 7;
  localparam int PTR_SEL_BIT = 6;
  localparam int CFG_LIN_BIT = 0;
  localparam int CFG_OFF_BIT = 1;
  localparam int CFG_GAIN_BIT = 2;
  localparam int CFG_SRC_BIT = 3;
  localparam logic [5:0] LOC_LIN_LAST = 6'h12;
  localparam logic [5:0] LOC_OFF_LO = 6'h13;
  localparam logic [5:0] LOC_OFF_HI = 6'h14;
  localparam logic [5:0] LOC_GAIN_LO = 6'h15;
  localparam logic [5:0] LOC_GAIN_HI = 6'h16;
  localparam int LIN_LOCS = 19;
  localparam int OFF_W = 14;
  localparam int GAIN_W = 13;
  localparam logic [13:0] OFF_RESET = 14'h2000;
  localparam logic [12:0] GAIN_RESET = 13'h1000;
  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 10000;
  localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LIN = 4'h2,
    ST_OFF = 4'h4,
    ST_GAIN = 4'h8
  } acc_state_e;
endpackage
`default_nettype wire

// ===== verilog/acc_cal_if.sv
`default_nettype none
interface acc_cal_if;
  logic [2:0] start;
  logic [2:0] done;
  logic busy;
  modport ctrl (output start, input done, input busy);
  modport engine (input start, output done, output busy);
endinterface
`default_nettype wire

// ===== verilog/acc_cal_engine.sv
`default_nettype none
module acc_cal_engine #(
  parameter int CAL_CYCLES = acc_pkg::CAL_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  acc_cal_if.engine cal
);
  // ****************************************************************
  // Sequencer: one calibration at a time, lowest start bit first.
  // ****************************************************************
  acc_pkg::acc_state_e state_q, state_d;
  logic [acc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] done_q, done_d;
  logic busy_q;
  wire logic [2:0] pend = cal.start & ~done_q;
  wire logic cnt_zero = (cnt_q == '0);
  wire logic [acc_pkg::CNT_W-1:0] cnt_load = acc_pkg::CNT_W'(CAL_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 3'h0;
    case (state_q)
      acc_pkg::ST_IDLE: begin
        cnt_d = cnt_load;
        if (pend[acc_pkg::CFG_LIN_BIT]) begin
          state_d = acc_pkg::ST_LIN;
        end else if (pend[acc_pkg::CFG_OFF_BIT]) begin
          state_d = acc_pkg::ST_OFF;
        end else if (pend[acc_pkg::CFG_GAIN_BIT]) begin
          state_d = acc_pkg::ST_GAIN;
        end
      end
      acc_pkg::ST_LIN, acc_pkg::ST_OFF, acc_pkg::ST_GAIN: begin
        if (cnt_zero) begin
          state_d = acc_pkg::ST_IDLE;
          done_d = state_q[3:1];
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = acc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= acc_pkg::ST_IDLE;
      cnt_q <= '0;
      done_q <= 3'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      busy_q <= (state_d != acc_pkg::ST_IDLE);
    end
  end

  assign cal.done = done_q;
  assign cal.busy = busy_q;

  a_run_holds: assert property (@(posedge mclk) disable iff (reset)
    (state_q != acc_pkg::ST_IDLE && !cnt_zero) |=> state_q == $past(state_q))
    else $error("calibration state left before its count ran out");
  a_lin_first: assert property (@(posedge mclk) disable iff (reset)
    (state_q == acc_pkg::ST_IDLE && pend[0]) |=> state_q == acc_pkg::ST_LIN)
    else $error("pending linearity calibration not started");
  a_done_at_end: assert property (@(posedge mclk) disable iff (reset)
    (state_q == acc_pkg::ST_OFF && cnt_zero) |=> done_q == 3'h2 ##1 done_q == 3'h0)
    else $error("offset done pulse wrong");
endmodule
`default_nettype wire

// ===== verification/acc_top_tb.sv
`default_nettype none
module acc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAL_N = 4;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] reg_sel = 2'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0][13:0] meas_offset = {14'h0123, 14'h0ABC};
  logic [1:0][12:0] meas_gain = {13'h0456, 13'h0789};
  logic [7:0] reg_rdata_q;
  logic [1:0][13:0] offset_coef_q;
  logic [1:0][12:0] gain_coef_q;
  logic [1:0] cal_source_q;
  logic [1:0] cal_busy_q;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ****************************************************************
  // Clock, design and run limit.
  // ****************************************************************
  always #5 mclk = ~mclk;
  acc_top #(.CAL_CYCLES(CAL_N)) acc_top_i (.mclk(mclk), .reset(reset), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .meas_offset(meas_offset),
    .meas_gain(meas_gain), .reg_rdata_q(reg_rdata_q), .offset_coef_q(offset_coef_q),
    .gain_coef_q(gain_coef_q), .cal_source_q(cal_source_q), .cal_busy_q(cal_busy_q));
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ****************************************************************
  // Shared tasks; the bus and wait tasks start and end 1 ns after a rising edge.
  // ****************************************************************
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    reg_sel = sel;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp, input string what);
    reg_sel = sel;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    chk({6'h00, reg_rdata_q}, {6'h00, exp}, what);
    @(posedge mclk);
    #1;
  endtask
  task automatic wait_idle(input int idx);
    int n;
    n = 0;
    while (cal_busy_q[idx] !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    chk({13'h0000, cal_busy_q[idx]}, 14'h0001, "busy");
    while (cal_busy_q[idx] !== 1'b0 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    chk({13'h0000, cal_busy_q[idx]}, 14'h0000, "busy end");
    @(posedge mclk);
    #1;
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset_values();
    rd_chk(2'h0, 8'hD7, "pointer reset");
    chk(offset_coef_q[0], 14'h2000, "offset reset");
    chk({1'b0, gain_coef_q[1]}, 14'h1000, "gain reset");
    chk({12'h000, cal_source_q}, 14'h0000, "source reset");
  endtask
  task automatic t_auto_increment();
    wr(2'h0, 8'h93);
    wr(2'h1, 8'hAB);
    wr(2'h1, 8'hFF);
    wr(2'h1, 8'hCD);
    wr(2'h1, 8'hFF);
    chk(offset_coef_q[0], 14'h3FAB, "offset pair");
    chk({1'b0, gain_coef_q[0]}, 14'h1FCD, "gain pair");
    chk(offset_coef_q[1], 14'h2000, "other converter");
    rd_chk(2'h0, 8'h97, "pointer after writes");
    wr(2'h0, 8'h93);
    rd_chk(2'h1, 8'hAB, "offset low");
    rd_chk(2'h1, 8'h3F, "offset high");
    rd_chk(2'h1, 8'hCD, "gain low");
    rd_chk(2'h1, 8'h1F, "gain high");
    rd_chk(2'h0, 8'h97, "pointer after reads");
  endtask
  task automatic t_wrap_and_select();
    wr(2'h0, 8'hFF);
    wr(2'h1, 8'h55);
    rd_chk(2'h0, 8'hC0, "wrapped pointer");
    wr(2'h0, 8'h53);
    wr(2'h1, 8'h12);
    rd_chk(2'h0, 8'h53, "pointer held");
    chk(offset_coef_q[1], 14'h2012, "converter one offset");
    wr(2'h0, 8'h05);
    wr(2'h1, 8'h5A);
    rd_chk(2'h1, 8'h5A, "linearity location");
    wr(2'h0, 8'h45);
    rd_chk(2'h1, 8'h00, "converter one linearity");
  endtask
  task automatic t_calibrations();
    wr(2'h2, 8'hF0);
    rd_chk(2'h2, 8'h00, "config upper bits");
    wr(2'h2, 8'h01);
    rd_chk(2'h2, 8'h01, "linearity bit set");
    wait_idle(0);
    rd_chk(2'h2, 8'h00, "linearity bit cleared");
    wr(2'h2, 8'h02);
    wait_idle(0);
    rd_chk(2'h2, 8'h00, "offset bit cleared");
    chk(offset_coef_q[0], 14'h0ABC, "measured offset");
    wr(2'h3, 8'h0A);
    chk({13'h0000, cal_source_q[1]}, 14'h0001, "external source");
    chk({13'h0000, cal_source_q[0]}, 14'h0000, "converter zero source kept");
    wait_idle(1);
    rd_chk(2'h3, 8'h08, "converter one offset bit cleared");
    chk(offset_coef_q[1], 14'h0123, "converter one measured offset");
    chk(offset_coef_q[0], 14'h0ABC, "converter zero offset kept");
    wr(2'h3, 8'h0C);
    chk({1'b0, gain_coef_q[0]}, 14'h1FCD, "converter zero gain kept");
    wait_idle(1);
    rd_chk(2'h3, 8'h08, "gain bit cleared");
    chk({1'b0, gain_coef_q[1]}, 14'h0456, "measured gain");
    chk(offset_coef_q[1], 14'h0123, "converter one offset kept");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 reset = 1'b0;
    t_reset_values();
    t_auto_increment();
    t_wrap_and_select();
    t_calibrations();
    end_sim();
  end
endmodule
`default_nettype wire
